/* File: common/cmd_decoder_pkg.sv */
// Constants and types shared by the I/O channel command decoder.
package cmd_decoder_pkg;

   // =========
   // Clock and timing
   // =========
   localparam int CLK_MHZ = 100;                 // Core clock rate
   localparam int SHORT_DELAY_US = 1;            // Short delay, least
   localparam int COMPAT_DELAY_MIN_US = 8;       // Compatibility delay, least
   localparam int COMPAT_DELAY_MAX_US = 32;      // Compatibility delay, most
   localparam int US_CYCLES = CLK_MHZ;           // Cycles per microsecond
   localparam int SHORT_DELAY_CYC = SHORT_DELAY_US * US_CYCLES;
   localparam int COMPAT_DELAY_CYC = COMPAT_DELAY_MIN_US * US_CYCLES;

   // =========
   // Register offsets (byte addresses, word aligned)
   // =========
   localparam logic [7:0] OFS_CTRL = 8'h00;      // Control and status
   localparam logic [7:0] OFS_CMD_ADDR = 8'h04;  // Command effective address
   localparam logic [7:0] OFS_CMD_GO = 8'h08;    // Command issue
   localparam logic [7:0] OFS_CMD_DATA = 8'h0C;  // Load result data
   localparam logic [7:0] OFS_INT_MASK = 8'h10;  // Interrupt mask state
   localparam logic [7:0] OFS_CHAN_EN = 8'h14;   // Channel enabled flags
   localparam logic [7:0] OFS_CSR_SEL = 8'h18;   // Channel status read select
   localparam logic [7:0] OFS_CSR_DATA = 8'h1C;  // Selected channel status

   // =========
   // Command address fields
   // =========
   localparam int CA_CMD_LSB = 12;               // Command class field
   localparam int CA_CMD_W = 4;
   localparam int CA_NUM_LSB = 4;                // Channel / interrupt number
   localparam int CA_NUM_W = 4;
   localparam int CA_ALT_BIT = 16;               // Alternate address space
   localparam int CA_LOW_W = 4;                  // Low delay address bits

   localparam logic [3:0] CMD_DELAY = 4'h0;      // Time delay class
   localparam logic [3:0] CMD_UNMASK = 4'h1;     // Interrupt unmask class
   localparam logic [3:0] CMD_ENDIS = 4'h2;      // Enable / disable class
   localparam logic [3:0] DELAY_SPAN = 4'h3;     // Split delay tail span
   localparam logic [3:0] CHAN_NODIS = 4'hF;     // Channel never disabled

   // =========
   // Channel status field values
   // =========
   localparam logic [3:0] CS_DISABLED = 4'h0;
   localparam logic [3:0] CS_ENABLED = 4'h1;
   localparam logic [3:0] ERR_EXTRA_REQ = 4'h5;  // Extra request code
   localparam logic [31:0] CSR_RESET = 32'h0000_0000;
   localparam int CSR_STAT_LSB = 28;             // Status field position
   localparam int CSR_ERR_LSB = 24;              // Error code position

   // =========
   // Access length encoding and exception codes
   // =========
   localparam logic [2:0] LEN_1 = 3'h1;
   localparam logic [2:0] LEN_2 = 3'h2;
   localparam logic [2:0] LEN_4 = 3'h4;
   localparam logic [3:0] EXC_INVALID_OP = 4'h1; // Invalid operation code
   localparam logic [3:0] EXC_AUTH = 4'h2;       // Authority / source refusal

   // Bits of the control register
   localparam int CTL_WRITE_BIT = 0;             // 1: Store, 0: Load
   localparam int CTL_LEN_LSB = 1;               // Access length
   localparam int CTL_SRC_BIT = 4;               // From system processor
   localparam int CTL_AUTH_BIT = 5;              // Authority check passed
   localparam int ST_BUSY_BIT = 8;               // Delay pending
   localparam int ST_EXC_BIT = 9;                // Exception raised
   localparam int ST_CODE_LSB = 12;              // Exception code

   // A command as issued by the processor side
   typedef struct packed {
      logic is_store;
      logic [2:0] len;
      logic from_cpu;
      logic auth_ok;
      logic [31:0] addr;
   } cmd_t;

   // DMA / bus master request from the channel side
   typedef struct packed {
      logic dma_req;
      logic bm_req;
      logic [3:0] chan;
   } chan_req_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_DELAY = 2'b01
   } delay_state_t;

endpackage : cmd_decoder_pkg

/* File: core/io_channel_command_decoder.sv */
// I/O channel controller command decoder with Wishbone register access.
// How it works
// - Length mismatch raises invalid-operation exception
// - Only authorised processor loads/stores accepted
// - Non-delay commands must be four-byte accesses
// - Pending delay holds off further commands
// - Delay never stalls DMA or bus master
// - One-byte delay at low nibble zero: 1us
// - Two/four-byte delays last 8 to 32us
// - Delay decode ignores alternate space bit
// - Addresses after delay also decode as delay
// - Delay load returns zero, store data dropped
// - Presented interrupt is masked automatically
// - Unmask command clears addressed interrupt mask
// - Enable/disable act on addressed channel
// - Enable load returns CHANNEL_STATUS_REGISTER, 0000 becomes 0001
// - Disable store turns 0001 into 0000 only
// - DMA on disabled channel: error, count pulse
// - Master on disabled channel: no feedback, check
// - Disable of channel fifteen is ignored
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
module io_channel_command_decoder #(
   parameter int NUM_CHAN = 16,                  // Channels
   parameter int NUM_IRQ = 16                    // Interrupt levels
)(
   input wire logic clk_i,                       // 100 MHz clock
   input wire logic rst_i,                       // Sync reset, active high
   input wire logic wb_cyc_i,                    // Wishbone cycle
   input wire logic wb_stb_i,                    // Wishbone strobe
   input wire logic wb_we_i,                     // Wishbone write
   input wire logic [7:0] wb_adr_i,              // Byte address
   input wire logic [3:0] wb_sel_i,              // Byte enables
   input wire logic [31:0] wb_dat_i,             // Write data
   output logic [31:0] wb_dat_o,                 // Read data
   output logic wb_ack_o,                        // Acknowledge
   input wire logic [NUM_IRQ-1:0] irq_i,         // Interrupt inputs (pins)
   output logic [NUM_IRQ-1:0] irq_present_o,     // Presented interrupts
   input wire logic dma_req_i,                   // DMA slave request (pin)
   input wire logic bm_req_i,                    // Bus master request (pin)
   input wire logic [3:0] req_chan_i,            // Requesting channel (pin)
   output logic terminal_count_pulse_o,          // Stop pulse to device
   output logic feedback_return_o,               // Selected feedback line
   output logic channel_check_o                  // Channel check
);

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   initial
   begin
      if (NUM_CHAN < 1 || NUM_CHAN > 16)
         $error("NUM_CHAN must be 1 to 16");
      if (NUM_IRQ < 1 || NUM_IRQ > 16)
         $error("NUM_IRQ must be 1 to 16");
   end

   localparam int CNT_W = $clog2(cmd_decoder_pkg::COMPAT_DELAY_CYC + 1);
   localparam logic [CNT_W-1:0] SHORT_CNT =
      CNT_W'(cmd_decoder_pkg::SHORT_DELAY_CYC);
   localparam logic [CNT_W-1:0] COMPAT_CNT =
      CNT_W'(cmd_decoder_pkg::COMPAT_DELAY_CYC);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [NUM_IRQ-1:0] irq_m_r;
   logic [NUM_IRQ-1:0] irq_s_r;
   cmd_decoder_pkg::chan_req_t req_m_r;
   cmd_decoder_pkg::chan_req_t req_s_r;
   cmd_decoder_pkg::chan_req_t req_d_r;

   // Two stages before any logic looks at a pin
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_m_r <= '0;
         irq_s_r <= '0;
         req_m_r <= '0;
         req_s_r <= '0;
         req_d_r <= '0;
      end
      else
      begin
         irq_m_r <= irq_i;
         irq_s_r <= irq_m_r;
         req_m_r <= '{dma_req_i, bm_req_i, req_chan_i};
         req_s_r <= req_m_r;
         req_d_r <= req_s_r;
      end
   end

   // ==========================================================
   // Software registers
   // ==========================================================
   logic [31:0] ctrl_r;
   logic [31:0] cmd_addr_r;
   logic [31:0] cmd_data_r;
   logic [3:0] csr_sel_r;
   logic exc_r;
   logic [3:0] exc_code_r;
   logic [31:0] csr_r [NUM_CHAN];
   logic [NUM_IRQ-1:0] mask_r;
   cmd_decoder_pkg::delay_state_t dly_state_r;
   logic [CNT_W-1:0] dly_cnt_r;

   wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic bus_wr = bus_req && wb_we_i && (wb_sel_i == 4'hF);
   wire logic go = bus_wr && (wb_adr_i == cmd_decoder_pkg::OFS_CMD_GO);
   wire logic delay_busy = (dly_state_r == cmd_decoder_pkg::ST_DELAY);

   // Control, address, channel select
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= 32'h0000_0000;
         cmd_addr_r <= 32'h0000_0000;
         csr_sel_r <= 4'h0;
      end
      else if (bus_wr)
      begin
         if (wb_adr_i == cmd_decoder_pkg::OFS_CTRL)
            ctrl_r <= wb_dat_i;
         if (wb_adr_i == cmd_decoder_pkg::OFS_CMD_ADDR)
            cmd_addr_r <= wb_dat_i;
         if (wb_adr_i == cmd_decoder_pkg::OFS_CSR_SEL)
            csr_sel_r <= wb_dat_i[3:0];
      end
   end

   // ==========================================================
   // Command decode
   // ==========================================================
   cmd_decoder_pkg::cmd_t cmd;
   assign cmd.is_store = ctrl_r[cmd_decoder_pkg::CTL_WRITE_BIT];
   assign cmd.len = ctrl_r[cmd_decoder_pkg::CTL_LEN_LSB +: 3];
   assign cmd.from_cpu = ctrl_r[cmd_decoder_pkg::CTL_SRC_BIT];
   assign cmd.auth_ok = ctrl_r[cmd_decoder_pkg::CTL_AUTH_BIT];
   assign cmd.addr = cmd_addr_r;

   // The alternate space bit is never looked at here
   wire logic [3:0] cls =
      cmd.addr[cmd_decoder_pkg::CA_CMD_LSB +: cmd_decoder_pkg::CA_CMD_W];
   wire logic [3:0] num =
      cmd.addr[cmd_decoder_pkg::CA_NUM_LSB +: cmd_decoder_pkg::CA_NUM_W];
   wire logic [3:0] low = cmd.addr[cmd_decoder_pkg::CA_LOW_W-1:0];
   // Tail addresses catch the halves of a split delay
   wire logic is_delay = (cls == cmd_decoder_pkg::CMD_DELAY) &&
      (low <= cmd_decoder_pkg::DELAY_SPAN) && (num == 4'h0);
   wire logic is_short = is_delay && (low == 4'h0) &&
      (cmd.len == cmd_decoder_pkg::LEN_1);
   wire logic is_compat = is_delay &&
      (cmd.len == cmd_decoder_pkg::LEN_2 ||
       cmd.len == cmd_decoder_pkg::LEN_4);
   // A split one-byte tail still counts as a delay, never an error
   wire logic is_tail = is_delay && (low != 4'h0) &&
      (cmd.len == cmd_decoder_pkg::LEN_1);
   wire logic is_unmask = (cls == cmd_decoder_pkg::CMD_UNMASK);
   wire logic is_endis = (cls == cmd_decoder_pkg::CMD_ENDIS);
   wire logic len_bad = is_delay ? !(is_short || is_compat || is_tail) :
      (cmd.len != cmd_decoder_pkg::LEN_4);
   wire logic src_ok = cmd.from_cpu && cmd.auth_ok;
   // Issue waits while a delay is pending; see the ack logic
   wire logic exec = go && !delay_busy;
   wire logic run = exec && src_ok && !len_bad;
   wire logic [3:0] chan = num;
   wire logic chan_ok = (32'(chan) < NUM_CHAN);

   // Exception flag and code
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         exc_r <= 1'b0;
         exc_code_r <= 4'h0;
      end
      else if (exec && !src_ok)
      begin
         exc_r <= 1'b1;
         exc_code_r <= cmd_decoder_pkg::EXC_AUTH;
      end
      else if (exec && len_bad)
      begin
         exc_r <= 1'b1;
         exc_code_r <= cmd_decoder_pkg::EXC_INVALID_OP;
      end
      else if (exec)
      begin
         exc_r <= 1'b0;
         exc_code_r <= 4'h0;
      end
   end

   // ==========================================================
   // Time delay
   // ==========================================================
   // Counted on the fixed core clock, not processor speed
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dly_state_r <= cmd_decoder_pkg::ST_IDLE;
         dly_cnt_r <= '0;
      end
      else
      begin
         unique case (dly_state_r)
            cmd_decoder_pkg::ST_IDLE:
            begin
               if (run && is_delay)
               begin
                  dly_state_r <= cmd_decoder_pkg::ST_DELAY;
                  dly_cnt_r <= is_compat ? COMPAT_CNT : SHORT_CNT;
               end
            end
            cmd_decoder_pkg::ST_DELAY:
            begin
               if (dly_cnt_r == CNT_W'(1))
                  dly_state_r <= cmd_decoder_pkg::ST_IDLE;
               dly_cnt_r <= dly_cnt_r - CNT_W'(1);
            end
         endcase
      end
   end

   // ==========================================================
   // Load result data
   // ==========================================================
   // Delay and unmask loads leave junk-free zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cmd_data_r <= 32'h0000_0000;
      else if (run && is_endis && !cmd.is_store && chan_ok)
         cmd_data_r <= csr_r[chan];
      else if (run)
         cmd_data_r <= 32'h0000_0000;
   end

   // ==========================================================
   // Interrupt masking
   // ==========================================================
   logic [NUM_IRQ-1:0] present_r;
   generate
      for (genvar i = 0; i < NUM_IRQ; i++)
      begin : g_irq
         wire logic unmask_hit = run && is_unmask && (32'(num) == i);
         // Presentation sets the mask; it wins over an unmask
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               mask_r[i] <= 1'b0;
               present_r[i] <= 1'b0;
            end
            else
            begin
               present_r[i] <= irq_s_r[i] && !mask_r[i];
               if (irq_s_r[i] && !mask_r[i])
                  mask_r[i] <= 1'b1;
               else if (unmask_hit)
                  mask_r[i] <= 1'b0;
            end
         end
      end
   endgenerate
   assign irq_present_o = present_r;

   // ==========================================================
   // Channel status registers
   // ==========================================================
   // Channel requests bypass the delay entirely
   wire logic dma_new = req_s_r.dma_req && !req_d_r.dma_req;
   wire logic bm_new = req_s_r.bm_req && !req_d_r.bm_req;
   generate
      for (genvar c = 0; c < NUM_CHAN; c++)
      begin : g_chan
         wire logic hit = run && is_endis && (32'(chan) == c);
         wire logic [3:0] stat =
            csr_r[c][cmd_decoder_pkg::CSR_STAT_LSB +: 4];
         wire logic dis = (stat != cmd_decoder_pkg::CS_ENABLED);
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               csr_r[c] <= cmd_decoder_pkg::CSR_RESET;
            else
            begin
               if (hit && !cmd.is_store &&
                   stat == cmd_decoder_pkg::CS_DISABLED)
                  csr_r[c][cmd_decoder_pkg::CSR_STAT_LSB +: 4] <=
                     cmd_decoder_pkg::CS_ENABLED;
               else if (hit && cmd.is_store &&
                        chan != cmd_decoder_pkg::CHAN_NODIS &&
                        stat == cmd_decoder_pkg::CS_ENABLED)
                  csr_r[c][cmd_decoder_pkg::CSR_STAT_LSB +: 4] <=
                     cmd_decoder_pkg::CS_DISABLED;
               if (dma_new && dis && 32'(req_s_r.chan) == c)
                  csr_r[c][cmd_decoder_pkg::CSR_ERR_LSB +: 4] <=
                     cmd_decoder_pkg::ERR_EXTRA_REQ;
            end
         end
      end
   endgenerate

   // Status of the requesting channel, disabled if out of range
   wire logic req_in_range = (32'(req_s_r.chan) < NUM_CHAN);
   wire logic req_dis = !req_in_range ||
      (csr_r[req_s_r.chan][cmd_decoder_pkg::CSR_STAT_LSB +: 4] !=
       cmd_decoder_pkg::CS_ENABLED);

   // Channel-side responses
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         terminal_count_pulse_o <= 1'b0;
         feedback_return_o <= 1'b0;
         channel_check_o <= 1'b0;
      end
      else
      begin
         terminal_count_pulse_o <= dma_new && req_dis;
         // Feedback only for enabled masters; check otherwise
         feedback_return_o <= req_s_r.bm_req && !req_dis;
         channel_check_o <= bm_new && req_dis;
      end
   end

   // ==========================================================
   // Wishbone slave
   // ==========================================================
   logic [31:0] rd_mux;
   logic [NUM_CHAN-1:0] en_vec;
   generate
      for (genvar c = 0; c < NUM_CHAN; c++)
      begin : g_en
         assign en_vec[c] = (csr_r[c][cmd_decoder_pkg::CSR_STAT_LSB +: 4] ==
            cmd_decoder_pkg::CS_ENABLED);
      end
   endgenerate

   // Unmapped addresses read zero and still ack
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (wb_adr_i)
         cmd_decoder_pkg::OFS_CTRL:
         begin
            rd_mux = ctrl_r;
            rd_mux[cmd_decoder_pkg::ST_BUSY_BIT] = delay_busy;
            rd_mux[cmd_decoder_pkg::ST_EXC_BIT] = exc_r;
            rd_mux[cmd_decoder_pkg::ST_CODE_LSB +: 4] = exc_code_r;
         end
         cmd_decoder_pkg::OFS_CMD_ADDR: rd_mux = cmd_addr_r;
         cmd_decoder_pkg::OFS_CMD_DATA: rd_mux = cmd_data_r;
         cmd_decoder_pkg::OFS_INT_MASK: rd_mux = 32'(mask_r);
         cmd_decoder_pkg::OFS_CHAN_EN: rd_mux = 32'(en_vec);
         cmd_decoder_pkg::OFS_CSR_SEL: rd_mux = 32'(csr_sel_r);
         cmd_decoder_pkg::OFS_CSR_DATA:
            rd_mux = (32'(csr_sel_r) < NUM_CHAN) ? csr_r[csr_sel_r] : '0;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // A command issue is held off until the delay expires
   wire logic stall = wb_we_i && (wb_adr_i == cmd_decoder_pkg::OFS_CMD_GO)
      && delay_busy;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req && !stall;
         wb_dat_o <= rd_mux;
      end
   end

endmodule : io_channel_command_decoder

/* File: verif/cmd_decoder_checker.sv */
// Port assertions for the I/O channel command decoder.
module cmd_decoder_checker #(
   parameter int NUM_IRQ = 16                  // Interrupt levels
)(
   input wire logic clk_i,                     // Clock
   input wire logic rst_i,                     // Sync reset
   input wire logic wb_cyc_i,                  // Cycle
   input wire logic wb_stb_i,                  // Strobe
   input wire logic wb_ack_o,                  // Acknowledge
   input wire logic [NUM_IRQ-1:0] irq_present_o, // Presentations
   input wire logic dma_req_i,                 // DMA request pin
   input wire logic bm_req_i,                  // Master request pin
   input wire logic terminal_count_pulse_o,    // Stop pulse
   input wire logic feedback_return_o,         // Feedback line
   input wire logic channel_check_o            // Channel check
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [3:0] dma_h_r;
   logic [3:0] bm_h_r;
   // Pin history spans the sync lag
   always_ff @(posedge clk_i)
   begin
      dma_h_r <= {dma_h_r[2:0], dma_req_i};
      bm_h_r <= {bm_h_r[2:0], bm_req_i};
   end
   // =========
   // Bus and pin relations
   // =========
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_tc_pulse;
      terminal_count_pulse_o |=> !terminal_count_pulse_o;
   endproperty
   a_tc_pulse: assert property (p_tc_pulse) else $error("tc long");
   property p_tc_cause;
      terminal_count_pulse_o |-> dma_h_r != 4'h0;
   endproperty
   a_tc_cause: assert property (p_tc_cause) else $error("stray tc");
   property p_chk_cause;
      channel_check_o |-> bm_h_r != 4'h0;
   endproperty
   a_chk_cause: assert property (p_chk_cause) else $error("stray chk");
   property p_chk_nofb;
      channel_check_o |-> !feedback_return_o;
   endproperty
   a_chk_nofb: assert property (p_chk_nofb) else $error("fb on chk");
   property p_fb_cause;
      feedback_return_o |-> bm_h_r != 4'h0;
   endproperty
   a_fb_cause: assert property (p_fb_cause) else $error("stray fb");
   property p_irq_once;
      |irq_present_o |=> (irq_present_o & $past(irq_present_o)) == '0;
   endproperty
   a_irq_once: assert property (p_irq_once) else $error("irq twice");
endmodule : cmd_decoder_checker

bind io_channel_command_decoder cmd_decoder_checker #(
   .NUM_IRQ(NUM_IRQ)
) u_cmd_decoder_checker (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .irq_present_o(irq_present_o),
   .dma_req_i(dma_req_i), .bm_req_i(bm_req_i),
   .terminal_count_pulse_o(terminal_count_pulse_o),
   .feedback_return_o(feedback_return_o),
   .channel_check_o(channel_check_o)
);

/* File: verif/processor_model.sv */
// Processor-side model issuing loads and stores over classic Wishbone.
module processor_model (
   input wire logic clk_i,                     // Clock
   input wire logic wb_ack_i,                  // Acknowledge
   input wire logic [31:0] wb_dat_i,           // Read data
   output logic wb_cyc_o,                      // Cycle
   output logic wb_stb_o,                      // Strobe
   output logic wb_we_o,                       // Write
   output logic [7:0] wb_adr_o,                // Address
   output logic [3:0] wb_sel_o,                // Byte enables
   output logic [31:0] wb_dat_o                // Write data
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus from time zero
   initial
   begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'hF;
      wb_dat_o = 32'h0;
   end
   // Classic cycle; n counts the wait
   task automatic xfer(input logic we, input logic [7:0] adr,
      input logic [31:0] wd, output logic [31:0] rd, output int n);
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_sel_o <= 4'hF;
      wb_adr_o <= adr;
      wb_dat_o <= wd;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_i !== 1'b1 && n < 5000);
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
   endtask : xfer
endmodule : processor_model

/* File: verif/io_channel_command_decoder_tb.sv */
// Self-checking testbench for the I/O channel command decoder.
module io_channel_command_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, req_chan_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [15:0] irq_i, irq_present_o;
   logic dma_req_i, bm_req_i, terminal_count_pulse_o;
   logic feedback_return_o, channel_check_o;
   int err_count = 0;
   int checked = 0;
   int tc_n = 0, chk_n = 0, fb_n = 0, irq_n = 0;
   io_channel_command_decoder u_io_channel_command_decoder (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_i(irq_i), .irq_present_o(irq_present_o),
      .dma_req_i(dma_req_i), .bm_req_i(bm_req_i), .req_chan_i(req_chan_i),
      .terminal_count_pulse_o(terminal_count_pulse_o),
      .feedback_return_o(feedback_return_o),
      .channel_check_o(channel_check_o));
   processor_model u_processor_model (
      .clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o),
      .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i),
      .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
   // 100 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Far-side pulse counters
   always @(posedge clk_i)
   begin
      tc_n += int'(terminal_count_pulse_o === 1'b1);
      chk_n += int'(channel_check_o === 1'b1);
      fb_n += int'(feedback_return_o === 1'b1);
      irq_n += int'(irq_present_o[2] === 1'b1);
   end
   // =========
   // Shared tasks
   // =========
   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      if (err_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // A hung bus fails the run
   task automatic xfer(input logic we, input logic [7:0] adr,
      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      u_processor_model.xfer(we, adr, wd, rd, n);
      if (n >= 5000)
      begin
         err_count++;
         tally_and_finish();
      end
   endtask : xfer
   task automatic rd_chk(input string nm, input logic [7:0] adr,
      input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] d;
      xfer(1'b0, adr, 32'h0, d);
      check(nm, d & mask, exp);
   endtask : rd_chk
   task automatic csr_chk(input string nm, input logic [3:0] ch,
      input logic [31:0] exp);
      logic [31:0] d;
      xfer(1'b1, 8'h18, {28'h0, ch}, d);
      rd_chk(nm, 8'h1C, '1, exp);
   endtask : csr_chk
   // Control, address, go; go data is dropped
   task automatic cmd(input logic [31:0] ctl, input logic [31:0] ca);
      logic [31:0] d;
      xfer(1'b1, 8'h00, ctl, d);
      xfer(1'b1, 8'h04, ca, d);
      xfer(1'b1, 8'h08, 32'hA5A5_A5A5, d);
   endtask : cmd
   // Held-off second go times the delay
   task automatic dly(input string nm, input logic [31:0] ctl,
      input logic [31:0] ca, input int lo, input int hi);
      logic [31:0] d;
      time t0;
      cmd(ctl, ca);
      t0 = $time;
      xfer(1'b1, 8'h08, 32'h0, d);
      t0 = ($time - t0) / 10;
      check(nm, {31'h0, t0 >= lo && t0 <= hi}, 32'h1);
      rd_chk(nm, 8'h00, 32'h200, 32'h0);
   endtask : dly
   task automatic pin(input logic bm, input logic [3:0] ch);
      req_chan_i <= ch;
      @(posedge clk_i);
      dma_req_i <= !bm;
      bm_req_i <= bm;
      repeat (8) @(posedge clk_i);
      dma_req_i <= 1'b0;
      bm_req_i <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask : pin
   // =========
   // Scenarios
   // =========
   task automatic scn_cmds();
      cmd(32'h38, 32'h2030);
      rd_chk("enable prior", 8'h0C, '1, 32'h0);
      csr_chk("enabled", 4'h3, 32'h1000_0000);
      cmd(32'h38, 32'h2030);
      rd_chk("reenable", 8'h0C, '1, 32'h1000_0000);
      cmd(32'h39, 32'h2030);
      csr_chk("disabled", 4'h3, 32'h0);
      cmd(32'h39, 32'h2030);
      csr_chk("redisable", 4'h3, 32'h0);
      cmd(32'h38, 32'h20F0);
      cmd(32'h39, 32'h20F0);
      rd_chk("chan 15 kept", 8'h14, '1, 32'h8000);
      cmd(32'h34, 32'h2040);
      rd_chk("len error", 8'h00, 32'hF200, 32'h1200);
      cmd(32'h28, 32'h2040);
      rd_chk("refused", 8'h00, 32'hF200, 32'h2200);
      cmd(32'h38, 32'h2040);
      rd_chk("exc clear", 8'h00, 32'h200, 32'h0);
   endtask : scn_cmds
   task automatic scn_delay();
      dly("short", 32'h32, 32'h0, 100, 200);
      dly("compat", 32'h34, 32'h1_0000, 800, 3200);
      dly("split", 32'h33, 32'h1, 100, 200);
   endtask : scn_delay
   task automatic scn_pins();
      cmd(32'h34, 32'h0);
      pin(1'b0, 4'h5);
      check("tc", 32'(tc_n), 32'h1);
      pin(1'b1, 4'h6);
      check("chk", 32'(chk_n), 32'h1);
      check("no fb", 32'(fb_n), 32'h0);
      pin(1'b1, 4'h4);
      check("fb", {31'h0, fb_n > 0}, 32'h1);
      csr_chk("extra req", 4'h5, 32'h0500_0000);
      csr_chk("bm no code", 4'h6, 32'h0);
      cmd(32'h38, 32'h2050);
      rd_chk("prior err", 8'h0C, '1, 32'h0500_0000);
      csr_chk("err kept", 4'h5, 32'h1500_0000);
   endtask : scn_pins
   task automatic scn_irq();
      irq_i[2] <= 1'b1;
      repeat (20) @(posedge clk_i);
      check("irq once", 32'(irq_n), 32'h1);
      rd_chk("masked", 8'h10, '1, 32'h4);
      irq_i[2] <= 1'b0;
      cmd(32'h38, 32'h1020);
      irq_i[2] <= 1'b1;
      repeat (8) @(posedge clk_i);
      check("irq again", 32'(irq_n), 32'h2);
   endtask : scn_irq
   // Main sequence
   initial
   begin
      rst_i = 1'b1;
      irq_i = 16'h0;
      dma_req_i = 1'b0;
      bm_req_i = 1'b0;
      req_chan_i = 4'h0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      scn_cmds();
      scn_delay();
      scn_pins();
      scn_irq();
      tally_and_finish();
   end
endmodule : io_channel_command_decoder_tb
